// [rps_sequencer.sv]
// reset and power-on sequencer top module
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.svh"
module rps_sequencer
    import rps_pkg::*;
(
    input  wire logic                 CLK_I,
    input  wire logic                 RSTN_I,
    input  wire logic                 EXT_RESET_N_I,
    input  wire logic                 SUPPLY_ABOVE_THR_I,
    input  wire logic                 SUPPLY_ABOVE_HYST_I,
    input  wire logic                 PERIPHERAL_RESET_FLAG_I,
    input  wire logic                 WDOG_TRIP_I,
    output logic                      POR_N_O,
    output logic                      CORE_RESET_O,
    output logic                      PERIPH_RESET_O,
    output logic                      WDOG_RESET_O,
    output logic                      STACK_CLEAR_O,
    output logic                      IRQ_MASK_ALL_O,
    output logic                      MODE_STATUS_CLEAR_O,
    output logic [`RPS_PC_W-1:0]      PC_LOAD_O
);
    // CLK_I is the instruction clock, twice the input clock rate
    rps_state_t r_r;
    rps_state_t r_nxt;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        r_nxt = r_r;
        // two-flop synchronisers for supply, external reset and watchdog pins
        r_nxt.sup_s1 = SUPPLY_ABOVE_THR_I;
        r_nxt.sup_s2 = r_r.sup_s1;
        r_nxt.ext_s1 = EXT_RESET_N_I;
        r_nxt.ext_s2 = r_r.ext_s1;
        r_nxt.wd_s1  = WDOG_TRIP_I;
        r_nxt.wd_s2  = r_r.wd_s1;
        // supply monitor with hysteresis, latched low state
        if (!SUPPLY_ABOVE_HYST_I) begin
            r_nxt.sup_lo = 1'b1;
        end else if (r_r.sup_s2) begin
            r_nxt.sup_lo = 1'b0;
        end
        // power-on counter, cleared on undervoltage
        if (r_r.sup_lo || !r_r.sup_s2) begin
            r_nxt.cnt   = '0;
            r_nxt.por_n = 1'b0;
        end else if (!r_r.por_n) begin
            r_nxt.cnt = r_r.cnt + `RPS_CNT_W'(1);
            if (r_r.cnt[`RPS_OVF_BIT]) begin
                r_nxt.por_n = 1'b1;
            end
        end
        // flag set then toggled twice -> peripheral reset pulse
        r_nxt.fl_prev = PERIPHERAL_RESET_FLAG_I;
        r_nxt.prst    = 1'b0;
        case (r_r.fl_st)
            RPS_FL_IDLE: begin
                if (PERIPHERAL_RESET_FLAG_I && !r_r.fl_prev) begin
                    r_nxt.fl_st = RPS_FL_SET;
                end
            end
            RPS_FL_SET: begin
                if (!PERIPHERAL_RESET_FLAG_I) begin
                    r_nxt.fl_st = RPS_FL_TG1;
                end
            end
            RPS_FL_TG1: begin
                if (PERIPHERAL_RESET_FLAG_I) begin
                    r_nxt.fl_st = RPS_FL_IDLE;
                    r_nxt.prst  = 1'b1;
                end
            end
            default: begin
                r_nxt.fl_st = RPS_FL_IDLE;
            end
        endcase
        // reset fan-out: full, watchdog, peripheral
        r_nxt.rst.wdog_rst   = !r_r.ext_s2;
        r_nxt.rst.core_rst   = !r_r.ext_s2 || r_r.wd_s2;
        r_nxt.rst.periph_rst = !r_r.ext_s2 || r_r.wd_s2 || r_r.prst;
        if (r_nxt.rst.core_rst) begin
            r_nxt.pc = `RPS_PC_INIT;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            r_r <= '{sup_lo: 1'b1, rst: '{1'b1, 1'b1, 1'b1}, pc: `RPS_PC_INIT,
                     fl_st: RPS_FL_IDLE, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from flops
    assign POR_N_O             = r_r.por_n;
    assign CORE_RESET_O        = r_r.rst.core_rst;
    assign PERIPH_RESET_O      = r_r.rst.periph_rst;
    assign WDOG_RESET_O        = r_r.rst.wdog_rst;
    assign STACK_CLEAR_O       = r_r.rst.core_rst;   // empty stacks
    assign IRQ_MASK_ALL_O      = r_r.rst.core_rst;   // mask interrupts
    assign MODE_STATUS_CLEAR_O = r_r.rst.core_rst;   // clear mode_status_reg
    assign PC_LOAD_O           = r_r.pc;
endmodule
`default_nettype wire

// [rps_defines.svh]
// constants for the reset and power-on sequencer
// Overview of operation
// - low external reset forces complete hardware reset
// - supply below threshold holds output low, counter held at zero
// - output high after 2^16 instruction cycles overflow
// - undervoltage drops output; restart above threshold
// - full reset clears stacks, masks, status, pc, peripherals
// - flag set then toggled twice resets peripherals only
// - watchdog trip resets core and peripherals, not watchdog
// - instruction clock is twice the input clock rate
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
`define RPS_CNT_W        17
`define RPS_OVF_BIT      16
`define RPS_CLK_NS       25
`define RPS_PC_INIT      14'h0000
`define RPS_PC_W         14
`define RPS_SEQ_W        2
`endif

// [rps_pkg.sv]
// types for the reset and power-on sequencer
`include "rps_defines.svh"
package rps_pkg;
    // peripheral-reset flag sequence, gray from IDLE through SET to TG1
    typedef enum logic [1:0] {
        RPS_FL_IDLE = 2'b00,
        RPS_FL_SET  = 2'b01,
        RPS_FL_TG1  = 2'b11
    } rps_fl_t;
    // reset outputs travelling together
    typedef struct packed {
        logic core_rst;
        logic periph_rst;
        logic wdog_rst;
    } rps_rst_t;
    // whole module state
    typedef struct packed {
        logic                    sup_s1;
        logic                    sup_s2;
        logic                    sup_lo;
        logic                    ext_s1;
        logic                    ext_s2;
        logic                    wd_s1;
        logic                    wd_s2;
        logic [`RPS_CNT_W-1:0]   cnt;
        logic                    por_n;
        logic                    fl_prev;
        rps_fl_t                 fl_st;
        logic                    prst;
        rps_rst_t                rst;
        logic [`RPS_PC_W-1:0]    pc;
    } rps_state_t;
endpackage

// [rps_checker.sv]
// assertions on the reset sequencer ports
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.svh"
module rps_checker (
    input wire logic CLK_I, RSTN_I, EXT_RESET_N_I, SUPPLY_ABOVE_HYST_I, WDOG_TRIP_I,
    input wire logic PERIPHERAL_RESET_FLAG_I, POR_N_O, CORE_RESET_O, PERIPH_RESET_O,
    input wire logic WDOG_RESET_O, STACK_CLEAR_O, IRQ_MASK_ALL_O, MODE_STATUS_CLEAR_O,
    input wire logic [`RPS_PC_W-1:0] PC_LOAD_O
);
    logic [17:0] n_r;
    logic        f;
    assign f = PERIPHERAL_RESET_FLAG_I;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // cycles since reset or undervoltage
    always_ff @(posedge CLK_I or negedge RSTN_I)
        if (!RSTN_I) n_r <= '0;
        else n_r <= SUPPLY_ABOVE_HYST_I ? n_r + 18'h1 : '0;
    ext_full_a: assert property ((!EXT_RESET_N_I)[*4] |->
        CORE_RESET_O && PERIPH_RESET_O && WDOG_RESET_O) else $error("ext reset");
    clear_all_a: assert property (CORE_RESET_O |-> STACK_CLEAR_O && IRQ_MASK_ALL_O &&
        MODE_STATUS_CLEAR_O && PC_LOAD_O == `RPS_PC_INIT) else $error("clear");
    trip_rst_a: assert property ((WDOG_TRIP_I && EXT_RESET_N_I)[*4] |->
        CORE_RESET_O && PERIPH_RESET_O && !WDOG_RESET_O) else $error("trip");
    uv_drop_a: assert property (!SUPPLY_ABOVE_HYST_I |-> ##2 !POR_N_O) else $error("uv");
    por_cause_a: assert property ($fell(POR_N_O) |-> !$past(SUPPLY_ABOVE_HYST_I, 2))
        else $error("por drop");
    por_early_a: assert property ($rose(POR_N_O) |-> n_r > 18'h10000) else $error("early");
    por_late_a: assert property (n_r == 18'h10040 |-> POR_N_O) else $error("late");
    flag_pulse_a: assert property (!f ##1 f ##1 !f ##1 f |-> ##[2:3]
        PERIPH_RESET_O && !WDOG_RESET_O && !CORE_RESET_O ##1 !PERIPH_RESET_O) else $error("flag");
endmodule
bind rps_sequencer rps_checker u_chk (.*);
`default_nettype wire

// [rps_board.sv]
// board reset source driving the external reset pin
`timescale 1ns/10ps
`default_nettype none
module rps_board (
    input  wire logic clk_i,
    input  wire logic pulse_i,
    output var logic  ext_n_o
);
    int n = 0;
    initial ext_n_o = 1'b0;
    // hold 2000 input clocks of two cycles each, then pulse on request
    always @(posedge clk_i) begin
        n <= n + 1;
        ext_n_o <= (n >= 4000) && !pulse_i;
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// bench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
`include "rps_defines.svh"
`define CHK(e, s) begin checks_done++; if ((e) !== (s)) begin num_errors++; \
    $display("FAIL outputs exp %h got %h", e, s); end end
module tb_top;
    logic CLK_I = 0, RSTN_I = 0, SUPPLY_ABOVE_THR_I = 1, SUPPLY_ABOVE_HYST_I = 1, p = 0;
    logic PERIPHERAL_RESET_FLAG_I = 0, WDOG_TRIP_I = 0, EXT_RESET_N_I, POR_N_O, CORE_RESET_O;
    logic PERIPH_RESET_O, WDOG_RESET_O, STACK_CLEAR_O, IRQ_MASK_ALL_O, MODE_STATUS_CLEAR_O;
    logic [`RPS_PC_W-1:0] PC_LOAD_O;
    logic [3:0] o, e, v = 4'h7, q[$];
    int num_errors = 0, checks_done = 0, seed = 12;
    rps_sequencer dut (.*);
    rps_board board (.clk_i(CLK_I), .pulse_i(p), .ext_n_o(EXT_RESET_N_I));
    assign o = {POR_N_O, CORE_RESET_O, PERIPH_RESET_O, WDOG_RESET_O};
    initial forever #12.5 CLK_I = ~CLK_I;
    task automatic close_out;
        if (q.size() != 0) num_errors++;
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // wait n cycles, or with all set until all notes are matched
    task automatic w(int n, bit all = 0);
        for (int k = 0; k < n && !(all && q.size() == 0); k++) @(negedge CLK_I);
    endtask
    // each change of the reset outputs is matched against the oldest note
    always @(negedge CLK_I) begin
        if (RSTN_I && o !== v) begin
            e = q.size() ? q.pop_front() : 4'hx;
            `CHK(e, o)
        end
        v = o;
    end
    initial begin
        w(3);
        RSTN_I = 1;
        q = '{4'h0, 4'h8};
        w(70000, 1);
        q = '{4'ha, 4'h8};
        for (int k = 0; k < 4; k++) begin
            PERIPHERAL_RESET_FLAG_I = ~k[0];
            w(1);
        end
        w(20, 1);
        q = '{4'he, 4'h8};
        WDOG_TRIP_I = 1;
        w(4 + ($random(seed) & 7));
        WDOG_TRIP_I = 0;
        w(20, 1);
        q = '{4'hf, 4'h8};
        p = 1;
        w(4 + ($random(seed) & 7));
        p = 0;
        w(20, 1);
        q = '{4'h0};
        SUPPLY_ABOVE_THR_I = 0;
        SUPPLY_ABOVE_HYST_I = 0;
        w(1 + ($random(seed) & 3));
        SUPPLY_ABOVE_HYST_I = 1;
        w(100);
        close_out();
    end
    // cut a hang short
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
